// >>> core/wake_pkg.sv
// shared constants, register map and types for the wake input monitor
package wake_pkg;
	// clock and timing
	localparam int CLK_PERIOD_NS = 20;
	localparam int FLT_SHORT_US = 16;
	localparam int FLT_LONG_US = 64;
	localparam int FLT_SHORT_CYC = (FLT_SHORT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int FLT_LONG_CYC = (FLT_LONG_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int FLT_CNT_W = 12;
	localparam int TICK_US = 1000;
	localparam int TICK_CYCLES_DEF = TICK_US * 1000 / CLK_PERIOD_NS;

	// channel layout: three wake pins, then two fail outputs used as wake inputs
	localparam int NUM_PINS = 3;
	localparam int NUM_FO = 2;
	localparam int NUM_CH = NUM_PINS + NUM_FO;

	// register byte offsets
	localparam logic [7:0] ADDR_WAKE_ENABLE_CTRL = 8'h00;
	localparam logic [7:0] ADDR_CURRENT_SOURCE_CTRL = 8'h04;
	localparam logic [7:0] ADDR_DETECT_FILTER_CTRL = 8'h08;
	localparam logic [7:0] ADDR_FIRST_TIMER_CTRL = 8'h0c;
	localparam logic [7:0] ADDR_SECOND_TIMER_CTRL = 8'h10;
	localparam logic [7:0] ADDR_WAKE_SOURCE_STATUS_A = 8'h14;
	localparam logic [7:0] ADDR_WAKE_SOURCE_STATUS_B = 8'h18;
	localparam logic [7:0] ADDR_PIN_LEVEL_STATUS = 8'h1c;
	localparam logic [7:0] ADDR_INT_MASK = 8'h20;
	localparam logic [7:0] ADDR_INT_STATUS = 8'h24;

	// field positions and reset values
	localparam int FO_CFG_LSB = 3;
	localparam int TIMER_ON_LSB = 8;
	localparam logic [4:0] WAKE_ENABLE_RST = 5'h00;
	localparam logic [5:0] CURRENT_SOURCE_RST = 6'h00;
	localparam logic [5:0] DETECT_FILTER_RST = 6'h00;
	localparam logic [4:0] INT_MASK_RST = 5'h00;

	// current source selection per pin
	localparam logic [1:0] CS_NONE = 2'h0;
	localparam logic [1:0] CS_PULL_DOWN = 2'h1;
	localparam logic [1:0] CS_PULL_UP = 2'h2;
	localparam logic [1:0] CS_AUTO = 2'h3;

	// detection mode per pin
	localparam logic [1:0] DET_STATIC_SHORT = 2'h0;
	localparam logic [1:0] DET_STATIC_LONG = 2'h1;
	localparam logic [1:0] DET_CYCLIC_FIRST = 2'h2;
	localparam logic [1:0] DET_CYCLIC_SECOND = 2'h3;

	typedef enum logic [1:0] {
		MODE_NORMAL = 2'h0,
		MODE_STOP = 2'h1,
		MODE_SLEEP = 2'h3,
		MODE_FAIL_SAFE = 2'h2
	} chip_mode_e;

	typedef struct packed {
		logic [7:0] on_time;
		logic [7:0] period;
	} timer_cfg_s;
endpackage : wake_pkg

// >>> core/wake_filter.sv
// stability filter for one wake channel, reports accepted edges
`timescale 1ns/100ps
module wake_filter
	import wake_pkg::*;
(
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// control
	input wire logic raw,
	input wire logic active,
	input wire logic long_sel,
	// result
	output logic level,
	output logic edge_pulse
);
	logic [FLT_CNT_W-1:0] cnt;
	logic [FLT_CNT_W-1:0] limit;

	assign limit = long_sel ? FLT_CNT_W'(FLT_LONG_CYC - 1) : FLT_CNT_W'(FLT_SHORT_CYC - 1);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt <= '0;
			level <= 1'b0;
			edge_pulse <= 1'b0;
		end else begin
			edge_pulse <= 1'b0;
			// outside the window nothing is evaluated and the accepted level holds
			if (!active || raw == level) begin
				// R4 crossing back restarts
				cnt <= '0;
			end else if (cnt >= limit) begin
				// R1 both edges signalled
				level <= raw;
				edge_pulse <= 1'b1;
				cnt <= '0;
			end else begin
				cnt <= cnt + 1'b1;
			end
		end
	end
endmodule : wake_filter

// >>> core/cyclic_timer.sv
// periodic on-window generator for cyclic sensing
`timescale 1ns/100ps
module cyclic_timer
	import wake_pkg::*;
#(
	parameter int TICK_CYCLES = TICK_CYCLES_DEF
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// configuration, period zero stops the timer
	input wire timer_cfg_s cfg,
	// window
	output logic window
);
	localparam int TW = (TICK_CYCLES > 1) ? $clog2(TICK_CYCLES) : 1;

	logic [TW-1:0] tick_cnt;
	logic [7:0] period_cnt;
	logic tick;

	if (TICK_CYCLES < 1) begin : g_chk
		$error("cyclic_timer: TICK_CYCLES must be at least 1");
	end

	assign tick = (tick_cnt == TW'(TICK_CYCLES - 1));

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tick_cnt <= '0;
			period_cnt <= '0;
			window <= 1'b0;
		end else if (cfg.period == 8'h00) begin
			tick_cnt <= '0;
			period_cnt <= '0;
			window <= 1'b0;
		end else begin
			tick_cnt <= tick ? '0 : tick_cnt + 1'b1;
			if (tick) begin
				period_cnt <= (period_cnt >= cfg.period - 8'h01) ? 8'h00 : period_cnt + 8'h01;
			end
			window <= (period_cnt < cfg.on_time);
		end
	end
endmodule : cyclic_timer

// >>> core/wake_input_monitor.sv
// wake input monitor: filters, cyclic sensing, current sources, status and APB registers
//
// Operation
// R1 - Each wake input signals both its rising and its falling threshold crossing.
// R2 - An accepted edge raises an interrupt in normal or stop mode and wakes the chip in sleep or fail-safe mode.
// R3 - Static sensing filters each input for a selectable 16 us or 64 us.
// R4 - The filter starts at a crossing and accepts only if the input stays across for the whole interval.
// R5 - Each wake pin has its own software-writable wake enable in the wake enable register.
// R6 - The pin that caused a wake is recorded in its wake-source bit of the first status register.
// R7 - In normal and stop mode the level register shows each pin level whether or not it is enabled.
// R8 - In cyclic sensing the level register holds the level sampled in the last active window.
// R9 - Fail outputs used as wake inputs have a fixed 16 us static filter and report in the second status register.
// R10 - Current source code 00 leaves the pin floating and is the reset value, 01 pulls down, 10 pulls up.
// R11 - Current source code 11 pulls up while the pin is high and pulls down while it is low.
// R12 - Detection code 00 is static with 16 us filter and code 01 static with 64 us filter.
// R13 - Detection codes 10 and 11 are cyclic on the first and second timer with 16 us filter.
// R14 - Static inputs are evaluated all the time, cyclic ones only inside their timer window; the code evaluates fail outputs only while enabled.
// R15 - The host assigns the same timer to a high-side output that powers the circuit on a cyclic pin.
// R16 - Wake-source bits stay set until software clears them.
//
// Local design decisions: register access over APB and the register offsets.
`timescale 1ns/100ps
module wake_input_monitor
	import wake_pkg::*;
#(
	parameter int TICK_CYCLES = TICK_CYCLES_DEF
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// chip operating mode
	input wire chip_mode_e chip_mode,
	// comparator outputs of the wake pins and the fail outputs
	input wire logic [NUM_PINS-1:0] wake_in,
	input wire logic [NUM_FO-1:0] fo_in,
	// current source controls
	output logic [NUM_PINS-1:0] pull_up_en,
	output logic [NUM_PINS-1:0] pull_down_en,
	// cyclic timer windows, for high-side outputs assigned to a timer
	output logic [1:0] timer_window,
	// events
	output logic wake_req,
	output logic irq
);
	// software registers
	logic [4:0] wake_enable_ctrl;
	logic [5:0] current_source_ctrl;
	logic [5:0] detect_filter_ctrl;
	timer_cfg_s first_timer_ctrl;
	timer_cfg_s second_timer_ctrl;
	logic [NUM_PINS-1:0] wake_source_status_a;
	logic [NUM_FO-1:0] wake_source_status_b;
	logic [NUM_PINS-1:0] pin_level_status;
	logic [NUM_CH-1:0] int_mask;
	logic [NUM_CH-1:0] int_status;

	// bus handshake
	logic wr_en;
	logic rd_hit;
	logic [31:0] next_prdata;

	// channel signals
	logic [NUM_CH-1:0] raw;
	logic [NUM_CH-1:0] active;
	logic [NUM_CH-1:0] long_sel;
	logic [NUM_CH-1:0] level;
	logic [NUM_CH-1:0] edge_pulse;
	logic [NUM_CH-1:0] wake_capable;
	logic [NUM_CH-1:0] int_set;
	logic [NUM_CH-1:0] wake_set;
	logic win_first;
	logic win_second;
	logic low_power;

	// ---------------------------------------------------------------
	// apb access: one wait state, the write lands on the completing edge
	// ---------------------------------------------------------------
	assign wr_en = psel & penable & pready & pwrite;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end else begin
			pready <= psel & penable & ~pready;
			pslverr <= psel & penable & ~pready & ~rd_hit;
			prdata <= (psel & penable & ~pready & ~pwrite) ? next_prdata : 32'h0000_0000;
		end
	end

	always_comb begin
		rd_hit = 1'b1;
		next_prdata = 32'h0000_0000;
		case (paddr)
			ADDR_WAKE_ENABLE_CTRL: next_prdata[4:0] = wake_enable_ctrl;
			ADDR_CURRENT_SOURCE_CTRL: next_prdata[5:0] = current_source_ctrl;
			ADDR_DETECT_FILTER_CTRL: next_prdata[5:0] = detect_filter_ctrl;
			ADDR_FIRST_TIMER_CTRL: next_prdata[15:0] = first_timer_ctrl;
			ADDR_SECOND_TIMER_CTRL: next_prdata[15:0] = second_timer_ctrl;
			ADDR_WAKE_SOURCE_STATUS_A: next_prdata[NUM_PINS-1:0] = wake_source_status_a;
			ADDR_WAKE_SOURCE_STATUS_B: next_prdata[NUM_FO-1:0] = wake_source_status_b;
			ADDR_PIN_LEVEL_STATUS: next_prdata[NUM_PINS-1:0] = pin_level_status;
			ADDR_INT_MASK: next_prdata[NUM_CH-1:0] = int_mask;
			ADDR_INT_STATUS: next_prdata[NUM_CH-1:0] = int_status;
			default: rd_hit = 1'b0;
		endcase
	end

	// ---------------------------------------------------------------
	// configuration registers
	// ---------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wake_enable_ctrl <= WAKE_ENABLE_RST;
			current_source_ctrl <= CURRENT_SOURCE_RST;
			detect_filter_ctrl <= DETECT_FILTER_RST;
			first_timer_ctrl <= '0;
			second_timer_ctrl <= '0;
			int_mask <= INT_MASK_RST;
		end else if (wr_en) begin
			case (paddr)
				// R5 per-pin wake enable
				ADDR_WAKE_ENABLE_CTRL: wake_enable_ctrl <= pwdata[4:0];
				ADDR_CURRENT_SOURCE_CTRL: current_source_ctrl <= pwdata[5:0];
				ADDR_DETECT_FILTER_CTRL: detect_filter_ctrl <= pwdata[5:0];
				ADDR_FIRST_TIMER_CTRL: first_timer_ctrl <= pwdata[15:0];
				ADDR_SECOND_TIMER_CTRL: second_timer_ctrl <= pwdata[15:0];
				ADDR_INT_MASK: int_mask <= pwdata[NUM_CH-1:0];
				default: ;
			endcase
		end
	end

	// ---------------------------------------------------------------
	// cyclic timers
	// ---------------------------------------------------------------
	cyclic_timer #(
		.TICK_CYCLES(TICK_CYCLES)
	) u_first_cyclic_timer (
		.pclk(pclk),
		.presetn(presetn),
		.cfg(first_timer_ctrl),
		.window(win_first)
	);

	cyclic_timer #(
		.TICK_CYCLES(TICK_CYCLES)
	) u_second_cyclic_timer (
		.pclk(pclk),
		.presetn(presetn),
		.cfg(second_timer_ctrl),
		.window(win_second)
	);

	// the host ties a high-side output to the same window to power the contact
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			timer_window <= 2'h0;
		end else begin
			// R15 window shared with high side
			timer_window <= {win_second, win_first};
		end
	end

	// ---------------------------------------------------------------
	// per-channel detection
	// ---------------------------------------------------------------
	assign raw = {fo_in, wake_in};

	for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_ch
		if (ch < NUM_PINS) begin : g_pin
			logic [1:0] det;
			logic [1:0] cs;
			logic sampled;

			assign det = detect_filter_ctrl[2*ch +: 2];
			assign cs = current_source_ctrl[2*ch +: 2];

			// R14 static always, cyclic in window
			// R13 cyclic timer selection
			always_comb begin
				case (det)
					DET_CYCLIC_FIRST: active[ch] = win_first;
					DET_CYCLIC_SECOND: active[ch] = win_second;
					default: active[ch] = 1'b1;
				endcase
			end

			// R12 static filter length
			// R3 16 or 64 us
			assign long_sel[ch] = (det == DET_STATIC_LONG);
			assign wake_capable[ch] = wake_enable_ctrl[ch];

			// sample follows the pin only inside the window, then holds
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					sampled <= 1'b0;
				end else if (active[ch]) begin
					sampled <= wake_in[ch];
				end
			end

			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					pin_level_status[ch] <= 1'b0;
				end else if (det[1]) begin
					// R8 last sampled level
					pin_level_status[ch] <= sampled;
				end else begin
					// R7 live level, enable ignored
					pin_level_status[ch] <= wake_in[ch];
				end
			end

			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					pull_up_en[ch] <= 1'b0;
					pull_down_en[ch] <= 1'b0;
				end else begin
					case (cs)
						// R10 floating, down, up
						CS_PULL_DOWN: begin
							pull_up_en[ch] <= 1'b0;
							pull_down_en[ch] <= 1'b1;
						end
						CS_PULL_UP: begin
							pull_up_en[ch] <= 1'b1;
							pull_down_en[ch] <= 1'b0;
						end
						// R11 follow detected level
						CS_AUTO: begin
							pull_up_en[ch] <= wake_in[ch];
							pull_down_en[ch] <= ~wake_in[ch];
						end
						default: begin
							pull_up_en[ch] <= 1'b0;
							pull_down_en[ch] <= 1'b0;
						end
					endcase
				end
			end
		end else begin : g_fo
			// R9 fixed short static filter
			assign active[ch] = wake_enable_ctrl[FO_CFG_LSB + ch - NUM_PINS];
			assign long_sel[ch] = 1'b0;
			assign wake_capable[ch] = wake_enable_ctrl[FO_CFG_LSB + ch - NUM_PINS];
		end

		wake_filter u_filter (
			.pclk(pclk),
			.presetn(presetn),
			.raw(raw[ch]),
			.active(active[ch]),
			.long_sel(long_sel[ch]),
			.level(level[ch]),
			.edge_pulse(edge_pulse[ch])
		);
	end

	// ---------------------------------------------------------------
	// events: interrupt in active modes, wake in low-power modes
	// ---------------------------------------------------------------
	assign low_power = (chip_mode == MODE_SLEEP) || (chip_mode == MODE_FAIL_SAFE);

	// R2 interrupt or wake by mode
	assign int_set = edge_pulse & {NUM_CH{~low_power}};
	assign wake_set = edge_pulse & wake_capable & {NUM_CH{low_power}};

	// a set in the same cycle as a one-to-clear keeps the bit
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wake_source_status_a <= '0;
			wake_source_status_b <= '0;
		end else begin
			// R6 record waking pin
			// R16 sticky until cleared
			wake_source_status_a <= (wake_source_status_a
				& ~((wr_en && paddr == ADDR_WAKE_SOURCE_STATUS_A) ? pwdata[NUM_PINS-1:0] : '0))
				| wake_set[NUM_PINS-1:0];
			// R9 fail outputs in second register
			wake_source_status_b <= (wake_source_status_b
				& ~((wr_en && paddr == ADDR_WAKE_SOURCE_STATUS_B) ? pwdata[NUM_FO-1:0] : '0))
				| wake_set[NUM_CH-1:NUM_PINS];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			int_status <= '0;
		end else begin
			int_status <= (int_status
				& ~((wr_en && paddr == ADDR_INT_STATUS) ? pwdata[NUM_CH-1:0] : '0))
				| int_set;
		end
	end

	// irq lags the status by one cycle so it stays a clean flop output
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq <= 1'b0;
			wake_req <= 1'b0;
		end else begin
			irq <= |(int_status & int_mask);
			// R2 wake request pulse
			wake_req <= |wake_set;
		end
	end
endmodule : wake_input_monitor

// >>> tb/wake_monitor.sv
// port-level assertion checker for the wake input monitor
`timescale 1ns/100ps
module wake_monitor
	import wake_pkg::*;
#(
	parameter int TICK_CYCLES = TICK_CYCLES_DEF
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// pins and events
	input wire chip_mode_e chip_mode,
	input wire logic [NUM_PINS-1:0] wake_in,
	input wire logic [NUM_FO-1:0] fo_in,
	input wire logic [NUM_PINS-1:0] pull_up_en,
	input wire logic [NUM_PINS-1:0] pull_down_en,
	input wire logic wake_req,
	input wire logic irq
);
	localparam int FLT_MIN = FLT_SHORT_CYC - 2;
	logic [NUM_CH-1:0] ch;
	logic [NUM_CH-1:0] ch_d;
	logic [9:0] quiet [NUM_CH];
	logic settled;
	logic wr_done;
	assign ch = {fo_in, wake_in};
	assign wr_done = psel && penable && pready && pwrite;
	// cycles since each channel input last moved, saturating
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ch_d <= '0;
			quiet <= '{default: '0};
		end else begin
			ch_d <= ch;
			for (int i = 0; i < NUM_CH; i++) begin
				quiet[i] <= (ch[i] != ch_d[i]) ? 10'h000 : quiet[i] + {9'h0, quiet[i] != 10'h3ff};
			end
		end
	end
	always_comb begin
		settled = 1'b0;
		for (int i = 0; i < NUM_CH; i++) begin
			if (quiet[i] >= FLT_MIN) begin
				settled = 1'b1;
			end
		end
	end
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	sequence setup_s;
		psel && !penable;
	endsequence
	sequence one_wait_s;
		!pready ##1 pready;
	endsequence
	access_wait_a: assert property (setup_s ##1 (psel && penable) |-> one_wait_s)
		else $error("apb answer not after exactly one wait state");
	ready_pulse_a: assert property (pready |=> !pready)
		else $error("pready held longer than one cycle");
	err_with_ready_a: assert property (pslverr |-> pready)
		else $error("pslverr outside a completing cycle");
	rdata_idle_a: assert property (!pready |-> prdata == 32'h0)
		else $error("read data not zero while idle");
	unmapped_err_a: assert property (pready && psel && paddr > ADDR_INT_STATUS |-> pslverr)
		else $error("unmapped address answered without error");
	mapped_ok_a: assert property (pready && psel && paddr[1:0] == 2'h0
		&& paddr <= ADDR_INT_STATUS |-> !pslverr)
		else $error("mapped register answered with error");
	wake_mode_a: assert property (wake_req |-> $past(chip_mode) inside {MODE_SLEEP, MODE_FAIL_SAFE})
		else $error("wake request outside low power mode");
	wake_filter_a: assert property (wake_req |-> settled)
		else $error("wake request without a stable input");
	pull_excl_a: assert property (pull_up_en != 3'h0 |-> (pull_up_en & pull_down_en) == 3'h0)
		else $error("pull up and pull down on together");
	pull_cause_a: assert property ($changed(pull_up_en) || $changed(pull_down_en) |->
		$past(wr_done) || $past(wr_done, 2) || $past(wake_in) != $past(wake_in, 2)
		|| $past(wake_in, 2) != $past(wake_in, 3))
		else $error("current source moved without write or pin change");
	wake_seen_c: cover property (wake_req);
endmodule : wake_monitor

bind wake_input_monitor wake_monitor #(.TICK_CYCLES(TICK_CYCLES)) u_mon (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.chip_mode(chip_mode), .wake_in(wake_in), .fo_in(fo_in), .pull_up_en(pull_up_en),
	.pull_down_en(pull_down_en), .wake_req(wake_req), .irq(irq)
);

// >>> tb/wake_contacts.sv
// behavioural switch contacts and comparators on the three wake pins
`timescale 1ns/100ps
module wake_contacts (
	// clock
	input wire logic pclk,
	// contact state and supply of each contact circuit
	input wire logic [2:0] closed,
	input wire logic [2:0] hs_on,
	// current sources from the monitor
	input wire logic [2:0] pull_up_en,
	input wire logic [2:0] pull_down_en,
	// comparator levels
	output logic [2:0] wake_in
);
	initial wake_in = 3'h0;
	always @(posedge pclk) begin
		for (int i = 0; i < 3; i++) begin
			if (closed[i] && hs_on[i]) begin
				wake_in[i] <= 1'b1;
			end else if (pull_up_en[i]) begin
				wake_in[i] <= 1'b1;
			end else if (pull_down_en[i]) begin
				wake_in[i] <= 1'b0;
			end else begin
				// open and unpulled: the pin wanders and never settles
				wake_in[i] <= ~wake_in[i];
			end
		end
	end
endmodule : wake_contacts

// >>> tb/wake_input_monitor_tb.sv
// self-checking bench for the wake input monitor
`timescale 1ns/100ps
module wake_input_monitor_tb;
	import wake_pkg::*;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	chip_mode_e chip_mode = MODE_NORMAL;
	logic [2:0] closed = 3'h0;
	logic [1:0] fo_in = 2'h0;
	logic [31:0] prdata;
	logic pready, pslverr, wake_req, irq, e;
	logic [2:0] wake_in, pull_up_en, pull_down_en;
	logic [1:0] timer_window;
	logic [31:0] q;
	int error_cnt = 0;
	int samples_checked = 0;
	int n;
	// rows: current source code [4:3], contact [2], pull up [1], pull down [0]
	logic [4:0] rows [7] = '{5'h00, 5'h09, 5'h12, 5'h1e, 5'h1a, 5'h09, 5'h19};
	always #10 pclk = ~pclk;
	wake_input_monitor #(.TICK_CYCLES(8)) dut (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.chip_mode(chip_mode), .wake_in(wake_in), .fo_in(fo_in), .pull_up_en(pull_up_en),
		.pull_down_en(pull_down_en), .timer_window(timer_window), .wake_req(wake_req), .irq(irq)
	);
	wake_contacts contacts (
		.pclk(pclk), .closed(closed), .hs_on(3'h7), .pull_up_en(pull_up_en),
		.pull_down_en(pull_down_en), .wake_in(wake_in)
	);
	task automatic test_done();
		$display("checks %0d errors %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : test_done
	task automatic chk(input string s, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			error_cnt++;
			$display("ERROR %s expected %h seen %h", s, exp, seen);
		end
	endtask : chk
	task automatic cyc(input int c);
		repeat (c) @(posedge pclk);
	endtask : cyc
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		k = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 40);
		// a slave that never answers counts against the run
		if (pready !== 1'b1) begin
			error_cnt++;
			$display("ERROR pready expected 1 seen %b", pready);
		end
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic rd(input logic [7:0] a, input logic [31:0] x);
		apb(1'b0, a, 32'h0);
		chk($sformatf("reg_%h", a), q, x);
	endtask : rd
	// edge must not show early, must show soon after the filter time, then is cleared
	task automatic ev(input logic [7:0] a, input logic [31:0] x, input int t);
		cyc(t - 12);
		rd(a, 32'h0);
		cyc(20);
		rd(a, x);
		apb(1'b1, a, x);
	endtask : ev
	task automatic wait_req();
		n = 0;
		while (wake_req !== 1'b1 && n < 900) begin
			@(posedge pclk);
			n++;
		end
		chk("wake_req", n > FLT_SHORT_CYC - 5 && n < 900, 1'b1);
	endtask : wait_req
	initial begin
		cyc(40000);
		error_cnt++;
		test_done();
	end
	initial begin
		cyc(16);
		presetn <= 1'b1;
		chk("pulls", {pull_up_en, pull_down_en}, 6'h00);
		for (int a = 0; a < 40; a += 4) begin
			if (a != 28) begin
				rd(8'(a), 32'h0);
			end
		end
		rd(8'h28, 32'h0);
		chk("slverr", e, 1'b1);
		foreach (rows[i]) begin
			apb(1'b1, ADDR_CURRENT_SOURCE_CTRL, {26'h0, {3{rows[i][4:3]}}});
			closed <= {3{rows[i][2]}};
			cyc(4);
			chk("pull_up", pull_up_en, {3{rows[i][1]}});
			chk("pull_down", pull_down_en, {3{rows[i][0]}});
		end
		apb(1'b1, ADDR_CURRENT_SOURCE_CTRL, 32'h15);
		cyc(10);
		apb(1'b1, ADDR_INT_STATUS, 32'h1f);
		apb(1'b1, ADDR_INT_MASK, 32'h1f);
		closed <= 3'h1;
		ev(ADDR_INT_STATUS, 32'h1, FLT_SHORT_CYC);
		rd(ADDR_PIN_LEVEL_STATUS, 32'h1);
		closed <= 3'h0;
		cyc(FLT_SHORT_CYC + 20);
		chk("irq", irq, 1'b1);
		apb(1'b1, ADDR_INT_MASK, 32'h0);
		cyc(2);
		chk("irq", irq, 1'b0);
		apb(1'b1, ADDR_INT_STATUS, 32'h1f);
		apb(1'b1, ADDR_INT_MASK, 32'h1f);
		// a pulse shorter than the filter time is dropped
		closed <= 3'h1;
		cyc(FLT_SHORT_CYC / 2);
		closed <= 3'h0;
		cyc(1000);
		rd(ADDR_INT_STATUS, 32'h0);
		apb(1'b1, ADDR_DETECT_FILTER_CTRL, 32'h4);
		closed <= 3'h2;
		ev(ADDR_INT_STATUS, 32'h2, FLT_LONG_CYC);
		apb(1'b1, ADDR_DETECT_FILTER_CTRL, 32'h0);
		apb(1'b1, ADDR_WAKE_ENABLE_CTRL, 32'h4);
		chip_mode <= MODE_SLEEP;
		closed <= 3'h0;
		cyc(1000);
		rd(ADDR_WAKE_SOURCE_STATUS_A, 32'h0);
		closed <= 3'h4;
		wait_req();
		rd(ADDR_INT_STATUS, 32'h0);
		chip_mode <= MODE_NORMAL;
		rd(ADDR_WAKE_SOURCE_STATUS_A, 32'h4);
		apb(1'b1, ADDR_WAKE_SOURCE_STATUS_A, 32'h4);
		rd(ADDR_WAKE_SOURCE_STATUS_A, 32'h0);
		apb(1'b1, ADDR_WAKE_ENABLE_CTRL, 32'h8);
		chip_mode <= MODE_FAIL_SAFE;
		fo_in <= 2'h1;
		wait_req();
		chip_mode <= MODE_NORMAL;
		rd(ADDR_WAKE_SOURCE_STATUS_B, 32'h1);
		rd(ADDR_WAKE_SOURCE_STATUS_A, 32'h0);
		apb(1'b1, ADDR_SECOND_TIMER_CTRL, 32'h0202);
		// pin0 cyclic on the stopped first timer, pin2 cyclic on the second
		apb(1'b1, ADDR_DETECT_FILTER_CTRL, 32'h32);
		cyc(50);
		chk("window", timer_window, 2'h2);
		apb(1'b1, ADDR_SECOND_TIMER_CTRL, 32'h0);
		// pin0 goes high outside its window, so its level must not follow
		closed <= 3'h1;
		cyc(1000);
		rd(ADDR_INT_STATUS, 32'h0);
		rd(ADDR_PIN_LEVEL_STATUS, 32'h4);
		apb(1'b1, ADDR_SECOND_TIMER_CTRL, 32'h0202);
		cyc(1000);
		rd(ADDR_INT_STATUS, 32'h4);
		rd(ADDR_PIN_LEVEL_STATUS, 32'h0);
		chip_mode <= MODE_STOP;
		apb(1'b1, ADDR_FIRST_TIMER_CTRL, 32'h0202);
		cyc(1000);
		chk("window", timer_window, 2'h3);
		rd(ADDR_INT_STATUS, 32'h5);
		rd(ADDR_PIN_LEVEL_STATUS, 32'h1);
		// mid-run reset returns every register to its default
		presetn <= 1'b0;
		cyc(2);
		presetn <= 1'b1;
		rd(ADDR_DETECT_FILTER_CTRL, 32'h0);
		rd(ADDR_CURRENT_SOURCE_CTRL, 32'h0);
		chk("pulls", {pull_up_en, pull_down_en}, 6'h00);
		// the filter restarts low, so the closed pin0 contact gives a rising edge
		cyc(1000);
		rd(ADDR_INT_STATUS, 32'h1);
		test_done();
	end
endmodule : wake_input_monitor_tb
